// ===== src/sstm_pkg.sv
// Constants, types and register layout for the standby sleep/timer controller.
// Assumes one 50 MHz system clock and a synchronous active-high reset.
package sstm_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_STANDBY_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_RTC_MODE_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_CLOCK_MODE_STATUS = 8'h08;
    localparam logic [7:0] ADDR_APB_CLOCK_ENABLE = 8'h0C;

    // Standby control fields
    localparam logic [15:0] STANDBY_UNLOCK_KEY = 16'h1ACC;
    localparam int KEY_LSB = 16;
    localparam int STBY_TYPE_LSB = 0;
    localparam int DBG_STBY_BIT = 2;
    localparam int PIN_HIZ_BIT = 4;
    localparam logic [1:0] STBY_TYPE_TIMER = 2'h0;
    localparam logic [1:0] STBY_TYPE_RESET = 2'h0;

    // Other control fields
    localparam int RTC_MODE_BIT = 0;
    localparam int APB1_EN_BIT = 0;
    localparam int APB2_EN_BIT = 1;

    // Status fields
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_RUN_LSB = 4;
    localparam int STAT_SLEEP_BIT = 8;
    localparam int STAT_TIMER_BIT = 9;
    localparam int STAT_WAKING_BIT = 10;
    localparam int STAT_CAUSE_LSB = 12;

    // Clock-mode codes
    localparam logic [2:0] CM_HRC = 3'h0;
    localparam logic [2:0] CM_MAIN = 3'h1;
    localparam logic [2:0] CM_PLL = 3'h2;
    localparam logic [2:0] CM_LRC = 3'h4;
    localparam logic [2:0] CM_SUB = 3'h5;

    // Reset source vector positions
    localparam int NUM_RST_SRC = 6;
    localparam int RST_PIN = 0;
    localparam int RST_LVD = 1;
    localparam int RST_SWDT = 2;
    localparam int RST_HWDT = 3;
    localparam int RST_CSV = 4;
    localparam int RST_AFD = 5;
    localparam int NUM_TIMER_WAKE = 9;

    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int REG_WAIT_US = 300;
    localparam int REG_WAIT_CYCLES_DEF = REG_WAIT_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {CAUSE_NONE, CAUSE_IRQ, CAUSE_RESET} sstm_cause_type;
    typedef enum {ST_RUN, ST_SLEEP, ST_TIMER, ST_REG_WAIT, ST_OSC_WAIT} sstm_state_type;

    typedef struct packed {
        logic cpu;
        logic ahb;
        logic apb0;
        logic apb1;
        logic apb2;
    } sstm_gate_type;

    typedef struct packed {
        logic ext_bus;
        logic hold;
        logic hiz;
    } sstm_pin_type;

endpackage : sstm_pkg

// ===== src/sstm_ctrl.sv
// Standby sleep/timer mode controller: clock gating, pin control, wake-up sequencing.
// Assumes a CPU that pulses i_wait_instr on wait-for-interrupt/event, interrupt
// lines on i_clk, and reset sources and oscillator ready flags from outside.
module sstm_ctrl #(
    parameter int REG_WAIT_CYCLES = sstm_pkg::REG_WAIT_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_core_deep_sleep_bit,
    input wire logic i_wait_instr,
    input wire logic [2:0] i_current_clock_mode_code,
    input wire logic i_periph_irq,
    input wire logic [sstm_pkg::NUM_TIMER_WAKE-1:0] i_timer_wake_irq,
    input wire logic [sstm_pkg::NUM_RST_SRC-1:0] i_reset_src,
    input wire logic i_hrc_ready,
    input wire logic i_lrc_ready,
    output sstm_pkg::sstm_gate_type o_gates,
    output sstm_pkg::sstm_pin_type o_pins,
    output logic o_periph_freeze,
    output logic o_debug_halt,
    output logic o_aon_run,
    output logic [2:0] o_run_mode,
    output logic o_run_mode_load
);
    import sstm_pkg::*;

    localparam int CNT_W = $clog2(REG_WAIT_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REG_WAIT_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Unlisted codes fall back to high-speed RC
    function automatic logic [2:0] map_run_mode(input logic [2:0] code);
        case (code)
            CM_MAIN: map_run_mode = CM_MAIN;
            CM_PLL: map_run_mode = CM_PLL;
            CM_LRC: map_run_mode = CM_LRC;
            CM_SUB: map_run_mode = CM_SUB;
            default: map_run_mode = CM_HRC;
        endcase
    endfunction : map_run_mode

    function automatic logic slow_mode(input logic [2:0] code);
        slow_mode = (code == CM_LRC) || (code == CM_SUB);
    endfunction : slow_mode

    function automatic logic timer_reset_hit(input logic [NUM_RST_SRC-1:0] src,
                                             input logic [2:0] code);
        timer_reset_hit = src[RST_PIN] | src[RST_LVD] | src[RST_HWDT] | src[RST_CSV]
            | (src[RST_AFD] & ((code == CM_MAIN) || (code == CM_PLL)));
    endfunction : timer_reset_hit

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [NUM_RST_SRC-1:0] rst_meta_q;
    logic [NUM_RST_SRC-1:0] rst_sync_q;
    logic [1:0] rdy_meta_q;
    logic [1:0] rdy_sync_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rst_meta_q <= '0;
            rst_sync_q <= '0;
            rdy_meta_q <= '0;
            rdy_sync_q <= '0;
        end
        else
        begin
            rst_meta_q <= i_reset_src;
            rst_sync_q <= rst_meta_q;
            rdy_meta_q <= {i_lrc_ready, i_hrc_ready};
            rdy_sync_q <= rdy_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [1:0] stby_type_q;
    logic dbg_stby_q;
    logic pin_hiz_q;
    logic rtc_mode_q;
    logic apb1_en_q;
    logic apb2_en_q;
    logic key_ok;
    logic wr_stb;

    assign wr_stb = i_wr && (i_addr == ADDR_STANDBY_CONTROL);
    assign key_ok = (i_wdata[KEY_LSB +: 16] == STANDBY_UNLOCK_KEY);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            stby_type_q <= STBY_TYPE_RESET;
            dbg_stby_q <= 1'b0;
            pin_hiz_q <= 1'b0;
        end
        else if (wr_stb && key_ok)
        begin
            stby_type_q <= i_wdata[STBY_TYPE_LSB +: 2];
            dbg_stby_q <= i_wdata[DBG_STBY_BIT];
            pin_hiz_q <= i_wdata[PIN_HIZ_BIT];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rtc_mode_q <= 1'b0;
            apb1_en_q <= 1'b1;
            apb2_en_q <= 1'b1;
        end
        else if (i_wr)
        begin
            if (i_addr == ADDR_RTC_MODE_CONTROL)
                rtc_mode_q <= i_wdata[RTC_MODE_BIT];
            if (i_addr == ADDR_APB_CLOCK_ENABLE)
            begin
                apb1_en_q <= i_wdata[APB1_EN_BIT];
                apb2_en_q <= i_wdata[APB2_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer

    sstm_state_type state_q;
    sstm_state_type state_d;
    logic [2:0] saved_code_q;
    logic [CNT_W-1:0] wait_cnt_q;
    logic reset_wake_q;
    sstm_cause_type cause_q;
    logic timer_entry_ok;
    logic timer_rst;
    logic timer_irq;
    logic sleep_rst;

    // Key-guarded settings must select timer type with debug standby off
    assign timer_entry_ok = (stby_type_q == STBY_TYPE_TIMER) && !dbg_stby_q && !rtc_mode_q;
    assign timer_rst = timer_reset_hit(rst_sync_q, saved_code_q);
    assign timer_irq = |i_timer_wake_irq;
    assign sleep_rst = |rst_sync_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
            begin
                if (i_wait_instr && !i_core_deep_sleep_bit)
                    state_d = ST_SLEEP;
                else if (i_wait_instr && timer_entry_ok)
                    state_d = ST_TIMER;
            end
            ST_SLEEP:
            begin
                if (sleep_rst)
                    state_d = ST_OSC_WAIT;
                else if (i_periph_irq)
                    state_d = ST_RUN;
            end
            ST_TIMER:
            begin
                if ((timer_rst || timer_irq) && slow_mode(saved_code_q))
                    state_d = ST_REG_WAIT;
                else if (timer_rst)
                    state_d = ST_OSC_WAIT;
                else if (timer_irq)
                    state_d = ST_RUN;
            end
            ST_REG_WAIT:
            begin
                if (wait_cnt_q == CNT_LAST)
                    state_d = reset_wake_q ? ST_OSC_WAIT : ST_RUN;
            end
            ST_OSC_WAIT:
            begin
                if (&rdy_sync_q)
                    state_d = ST_RUN;
            end
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    // Variant of sleep/timer is the clock mode captured at entry
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            saved_code_q <= CM_HRC;
        else if (state_q == ST_RUN && state_d != ST_RUN)
            saved_code_q <= i_current_clock_mode_code;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            reset_wake_q <= 1'b0;
        else if (state_q == ST_TIMER)
            reset_wake_q <= timer_rst;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            wait_cnt_q <= '0;
        else if (state_q == ST_REG_WAIT && wait_cnt_q != CNT_LAST)
            wait_cnt_q <= wait_cnt_q + 1'b1;
        else
            wait_cnt_q <= '0;
    end

    // Run mode: reset wake forces high-speed RC, interrupt wake uses mapping
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_run_mode <= CM_HRC;
            o_run_mode_load <= 1'b0;
            cause_q <= CAUSE_NONE;
        end
        else
        begin
            o_run_mode_load <= 1'b0;
            if (state_d == ST_OSC_WAIT && state_q != ST_OSC_WAIT)
            begin
                o_run_mode <= CM_HRC;
                cause_q <= CAUSE_RESET;
            end
            else if (state_d == ST_RUN && state_q != ST_RUN)
            begin
                o_run_mode_load <= 1'b1;
                if (state_q != ST_OSC_WAIT && !(state_q == ST_REG_WAIT && reset_wake_q))
                begin
                    o_run_mode <= map_run_mode(saved_code_q);
                    cause_q <= CAUSE_IRQ;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock gates, pins and freeze controls

    sstm_gate_type gate_d;
    sstm_pin_type pin_d;
    logic deep_d;

    always_comb
    begin
        deep_d = (state_d == ST_TIMER) || (state_d == ST_REG_WAIT)
            || (state_d == ST_OSC_WAIT);
        gate_d = '{cpu: 1'b1, ahb: 1'b1, apb0: 1'b1, apb1: 1'b1, apb2: 1'b1};
        pin_d = '{ext_bus: 1'b1, hold: 1'b0, hiz: 1'b0};
        if (state_d == ST_SLEEP)
        begin
            gate_d.cpu = 1'b0;
            gate_d.apb1 = apb1_en_q;
            gate_d.apb2 = apb2_en_q;
        end
        else if (deep_d)
        begin
            gate_d = '0;
            pin_d.ext_bus = 1'b0;
            pin_d.hiz = pin_hiz_q;
            pin_d.hold = !pin_hiz_q;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_gates <= '{cpu: 1'b1, ahb: 1'b1, apb0: 1'b1, apb1: 1'b1, apb2: 1'b1};
            o_pins <= '{ext_bus: 1'b1, hold: 1'b0, hiz: 1'b0};
            o_periph_freeze <= 1'b0;
            o_debug_halt <= 1'b0;
        end
        else
        begin
            o_gates <= gate_d;
            o_pins <= pin_d;
            o_periph_freeze <= deep_d;
            o_debug_halt <= deep_d;
        end
    end

    // Watchdog, watch counter, RTC, supervisor, oscillators never gated here
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_aon_run <= 1'b1;
        else
            o_aon_run <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_rdata <= '0;
        else
        begin
            o_rdata <= '0;
            if (i_rd)
            begin
                case (i_addr)
                    ADDR_STANDBY_CONTROL:
                    begin
                        o_rdata[STBY_TYPE_LSB +: 2] <= stby_type_q;
                        o_rdata[DBG_STBY_BIT] <= dbg_stby_q;
                        o_rdata[PIN_HIZ_BIT] <= pin_hiz_q;
                    end
                    ADDR_RTC_MODE_CONTROL: o_rdata[RTC_MODE_BIT] <= rtc_mode_q;
                    ADDR_APB_CLOCK_ENABLE:
                    begin
                        o_rdata[APB1_EN_BIT] <= apb1_en_q;
                        o_rdata[APB2_EN_BIT] <= apb2_en_q;
                    end
                    ADDR_CLOCK_MODE_STATUS:
                    begin
                        o_rdata[STAT_CODE_LSB +: 3] <= i_current_clock_mode_code;
                        o_rdata[STAT_RUN_LSB +: 3] <= o_run_mode;
                        o_rdata[STAT_SLEEP_BIT] <= (state_q == ST_SLEEP);
                        o_rdata[STAT_TIMER_BIT] <= (state_q == ST_TIMER);
                        o_rdata[STAT_WAKING_BIT] <= (state_q == ST_REG_WAIT)
                            || (state_q == ST_OSC_WAIT);
                        o_rdata[STAT_CAUSE_LSB +: 2] <= cause_q;
                    end
                    default: o_rdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_sleep_cpu_gate: assert property ((state_q == ST_SLEEP) |->
        (!o_gates.cpu && o_gates.ahb && o_pins.ext_bus && !o_pins.hiz))
        else $error("sleep gating wrong");
    a_sleep_apb_enables: assert property ((state_q == ST_SLEEP) |->
        (o_gates.apb0 && o_gates.apb1 == $past(apb1_en_q) && o_gates.apb2 == $past(apb2_en_q)))
        else $error("sleep apb gating wrong");
    a_sleep_entry_seq: assert property ((state_q == ST_RUN && i_wait_instr
        && !i_core_deep_sleep_bit) |=> (state_q == ST_SLEEP && !o_gates.cpu))
        else $error("sleep entry failed");
    a_sleep_irq_fast: assert property ((state_q == ST_SLEEP && i_periph_irq
        && !sleep_rst) |=> (state_q == ST_RUN && o_run_mode == map_run_mode(saved_code_q)
        && o_run_mode_load))
        else $error("sleep interrupt wake wrong");
    a_timer_all_off: assert property ((state_q == ST_TIMER) |->
        (o_gates == '0 && o_periph_freeze && o_debug_halt && o_aon_run))
        else $error("timer gating wrong");
    a_timer_pin_ctl: assert property ((state_q == ST_TIMER) |->
        (!o_pins.ext_bus && o_pins.hiz == $past(pin_hiz_q) && o_pins.hold != o_pins.hiz))
        else $error("timer pin control wrong");
    a_timer_swdt_ignore: assert property ((state_q == ST_TIMER && !timer_irq
        && rst_sync_q == (NUM_RST_SRC'(1) << RST_SWDT)) |=> (state_q == ST_TIMER))
        else $error("software watchdog woke timer");
    a_timer_slow_wait: assert property ((state_q == ST_TIMER && timer_irq
        && slow_mode(saved_code_q)) |=> (state_q == ST_REG_WAIT)[*8])
        else $error("regulator wait skipped");
    a_reset_wake_hrc: assert property ((state_q == ST_OSC_WAIT) |->
        (o_run_mode == CM_HRC))
        else $error("reset wake mode wrong");
    a_osc_wait_hold: assert property ((state_q == ST_OSC_WAIT && !(&rdy_sync_q)) |=>
        (state_q == ST_OSC_WAIT))
        else $error("oscillator wait cut short");
    a_key_guard: assert property ((wr_stb && !key_ok) |=>
        ($stable(stby_type_q) && $stable(dbg_stby_q) && $stable(pin_hiz_q)))
        else $error("unkeyed write took effect");

    c_sleep_irq: cover property ((state_q == ST_SLEEP) ##1 (state_q == ST_RUN));
    c_timer_reset: cover property ((state_q == ST_TIMER) ##1 (state_q == ST_OSC_WAIT)
        ##[1:50] (state_q == ST_RUN));
    c_reg_wait_done: cover property ((state_q == ST_REG_WAIT) ##1 (state_q == ST_RUN));
    c_timer_irq: cover property ((state_q == ST_TIMER) ##1 (state_q == ST_RUN));

endmodule : sstm_ctrl

// ===== testbench/sstm_src_model.sv
// Far-side model: reset sources and the two internal RC oscillators.
// Assumes the bench pulses i_req for one cycle to raise a reset source.
module sstm_src_model #(
    parameter int RDY_DLY = 20
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [sstm_pkg::NUM_RST_SRC-1:0] i_req,
    output logic [sstm_pkg::NUM_RST_SRC-1:0] o_reset_src,
    output logic o_hrc_ready,
    output logic o_lrc_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import sstm_pkg::*;

    int unsigned src_cnt;
    int unsigned rdy_cnt;
    logic [NUM_RST_SRC-1:0] src_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Source stays high long enough to pass the two-stage synchroniser, then drops
    always_ff @(posedge i_clk)
    begin
        if (i_rst || (src_cnt == 1))
        begin
            src_q <= '0;
            src_cnt <= 0;
        end
        else if (|i_req)
        begin
            src_q <= i_req;
            src_cnt <= 4;
        end
        else if (src_cnt != 0)
            src_cnt <= src_cnt - 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A reset restarts both oscillators; the low-speed one settles last
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdy_cnt <= 0;
        else if (|i_req)
            rdy_cnt <= RDY_DLY;
        else if (rdy_cnt != 0)
            rdy_cnt <= rdy_cnt - 1;
    end

    assign o_reset_src = src_q;
    assign o_hrc_ready = (rdy_cnt <= RDY_DLY / 2);
    assign o_lrc_ready = (rdy_cnt == 0);
endmodule : sstm_src_model

// ===== testbench/test_standby_sleep_timer_mode_ctrl.sv
// Self-checking bench for the standby sleep/timer controller.
// Assumes the controller is built with a short regulator wait of 10 cycles.
module test_standby_sleep_timer_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import sstm_pkg::*;

    localparam int RDY = 20;
    localparam int RWAIT = 10;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic deep = 1'b0;
    logic wait_p = 1'b0;
    logic [2:0] code = 3'h0;
    logic irq = 1'b0;
    logic [NUM_TIMER_WAKE-1:0] t_irq = '0;
    logic [NUM_RST_SRC-1:0] req = '0;
    logic [NUM_RST_SRC-1:0] rst_src;
    logic hrc_rdy;
    logic lrc_rdy;
    logic [31:0] o_rdata;
    sstm_gate_type o_gates;
    sstm_pin_type o_pins;
    logic o_freeze;
    logic o_dbg;
    logic o_aon;
    logic [2:0] o_mode;
    logic o_load;
    int fail_count = 0;
    int checked = 0;
    int n_wait;
    logic [2:0] tcode [7] = '{3'h1, 3'h4, 3'h2, 3'h2, 3'h1, 3'h0, 3'h2};
    int tsrc [7] = '{RST_SWDT, RST_AFD, RST_AFD, RST_PIN, RST_LVD, RST_HWDT, RST_CSV};
    logic twake [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

    sstm_ctrl #(.REG_WAIT_CYCLES(RWAIT)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_core_deep_sleep_bit(deep), .i_wait_instr(wait_p), .i_current_clock_mode_code(code),
        .i_periph_irq(irq), .i_timer_wake_irq(t_irq), .i_reset_src(rst_src),
        .i_hrc_ready(hrc_rdy), .i_lrc_ready(lrc_rdy), .o_gates(o_gates), .o_pins(o_pins),
        .o_periph_freeze(o_freeze), .o_debug_halt(o_dbg), .o_aon_run(o_aon),
        .o_run_mode(o_mode), .o_run_mode_load(o_load));

    sstm_src_model #(.RDY_DLY(RDY)) far (.i_clk(i_clk), .i_rst(i_rst), .i_req(req),
        .o_reset_src(rst_src), .o_hrc_ready(hrc_rdy), .o_lrc_ready(lrc_rdy));

    initial
    begin
        forever #10 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Counts: %0d checked, %0d mismatches", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("rdata", e, o_rdata);
    endtask : rd

    // Wait pulse with the deep-sleep bit already settled beside it
    task automatic go(logic d, logic [2:0] c);
        @(posedge i_clk);
        deep <= d;
        code <= c;
        wait_p <= 1'b1;
        @(posedge i_clk);
        wait_p <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask : go

    // Bounded wait for the run-mode load pulse
    task automatic wake_wait();
        n_wait = 0;
        while (o_load !== 1'b1)
        begin
            @(posedge i_clk);
            #1 n_wait++;
            if (n_wait > 200)
            begin
                chk("wake timeout", 32'h1, 32'h0);
                wrap_up();
            end
        end
        chk("gates run", 32'h1F, 32'(o_gates));
        chk("pins run", 32'h4, 32'(o_pins));
    endtask : wake_wait

    task automatic pulse_rst(int s);
        @(posedge i_clk);
        req <= NUM_RST_SRC'(1) << s;
        @(posedge i_clk);
        req <= '0;
        wake_wait();
    endtask : pulse_rst

    task automatic tirq(int b);
        @(posedge i_clk);
        t_irq <= NUM_TIMER_WAKE'(1) << b;
        wake_wait();
        @(posedge i_clk);
        t_irq <= '0;
    endtask : tirq

    function automatic logic [31:0] exp_mode(logic [2:0] c);
        return (c == 3'h3 || c > 3'h5) ? 32'h0 : 32'(c);
    endfunction : exp_mode

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(ADDR_STANDBY_CONTROL, 32'h0);
        rd(ADDR_APB_CLOCK_ENABLE, 32'h3);
        rd(8'h10, 32'h0);
        wr(ADDR_STANDBY_CONTROL, 32'h1ACB0010);
        rd(ADDR_STANDBY_CONTROL, 32'h0);
        wr(ADDR_STANDBY_CONTROL, 32'h1ACC0014);
        rd(ADDR_STANDBY_CONTROL, 32'h14);
        wr(ADDR_APB_CLOCK_ENABLE, 32'h2);
        go(1'b1, 3'h1);
        chk("debug standby refuses timer", 32'h1F, 32'(o_gates));
        wr(ADDR_STANDBY_CONTROL, 32'h1ACC0000);
        wr(ADDR_RTC_MODE_CONTROL, 32'h1);
        rd(ADDR_RTC_MODE_CONTROL, 32'h1);
        go(1'b1, 3'h1);
        chk("rtc mode refuses timer", 32'h1F, 32'(o_gates));
        wr(ADDR_RTC_MODE_CONTROL, 32'h0);
        $display("Test registers done");
        for (int c = 0; c < 8; c++)
        begin
            go(1'b0, 3'(c));
            chk("gates sleep", 32'h0D, 32'(o_gates));
            chk("pins sleep", 32'h4, 32'(o_pins));
            chk("aon sleep", 32'h1, 32'(o_aon));
            chk("freeze sleep", 32'h0, 32'(o_freeze));
            @(posedge i_clk);
            irq <= 1'b1;
            wake_wait();
            chk("mode sleep irq", exp_mode(3'(c)), 32'(o_mode));
            chk("no osc wait", 32'h1, 32'(n_wait <= 3));
            @(posedge i_clk);
            irq <= 1'b0;
        end
        for (int s = 0; s < NUM_RST_SRC; s++)
        begin
            go(1'b0, 3'h2);
            pulse_rst(s);
            chk("mode sleep reset", 32'h0, 32'(o_mode));
            chk("osc wait", 32'h1, 32'(n_wait >= RDY));
        end
        $display("Test sleep done");
        for (int i = 0; i < NUM_TIMER_WAKE; i++)
        begin
            wr(ADDR_STANDBY_CONTROL, 32'h1ACC0000 | (32'(i % 2) << PIN_HIZ_BIT));
            go(1'b1, 3'(i % 3));
            chk("gates timer", 32'h0, 32'(o_gates));
            chk("pins timer", (i % 2) ? 32'h1 : 32'h2, 32'(o_pins));
            chk("freeze timer", 32'h1, 32'(o_freeze));
            chk("debug timer", 32'h1, 32'(o_dbg));
            chk("aon timer", 32'h1, 32'(o_aon));
            tirq(i);
            chk("mode timer irq", exp_mode(3'(i % 3)), 32'(o_mode));
            chk("no osc wait", 32'h1, 32'(n_wait <= 3));
        end
        for (int k = 0; k < 7; k++)
        begin
            go(1'b1, tcode[k]);
            if (twake[k])
            begin
                pulse_rst(tsrc[k]);
                chk("mode timer reset", 32'h0, 32'(o_mode));
                chk("osc wait", 32'h1, 32'(n_wait >= RDY));
            end
            else
            begin
                @(posedge i_clk);
                req <= NUM_RST_SRC'(1) << tsrc[k];
                @(posedge i_clk);
                req <= '0;
                repeat (30) @(posedge i_clk);
                #1 chk("reset ignored", 32'h0, 32'(o_gates));
                tirq(0);
            end
        end
        $display("Test timer done");
        for (int c = 4; c < 6; c++)
        begin
            go(1'b1, 3'(c));
            tirq(3);
            chk("mode slow irq", 32'(c), 32'(o_mode));
            chk("regulator wait", 32'h1, 32'(n_wait >= RWAIT));
            rd(ADDR_CLOCK_MODE_STATUS, 32'h1000 | (32'(c) << 4) | 32'(c));
        end
        go(1'b1, 3'h5);
        pulse_rst(RST_PIN);
        chk("mode slow reset", 32'h0, 32'(o_mode));
        chk("regulator wait", 32'h1, 32'(n_wait >= RWAIT + RDY / 2));
        rd(ADDR_CLOCK_MODE_STATUS, 32'h2005);
        $display("Test slow wake done");
        wrap_up();
    end
endmodule : test_standby_sleep_timer_mode_ctrl
